// *** logic/fbof_cfg.svh ***
// offsets, field positions, reset values and timing counts of the octet framer
`ifndef FBOF_CFG_SVH
`define FBOF_CFG_SVH
`define FBOF_ADDR_CTRL    12'h000
`define FBOF_ADDR_DIV     12'h004
`define FBOF_ADDR_STAT    12'h008
`define FBOF_CTRL_FD_BIT  0
`define FBOF_STAT_TXEN    8
`define FBOF_STAT_RTS     9
`define FBOF_STAT_TXBUSY  10
`define FBOF_STAT_RXBUSY  11
`define FBOF_CLK_HZ       200000000
`define FBOF_BAUD_HZ      9600
`define FBOF_DIV_RESET    (`FBOF_CLK_HZ / `FBOF_BAUD_HZ)
`define FBOF_IDLE_LONG    6'd11
`define FBOF_IDLE_MAX     6'h3f
`define FBOF_SHORT_MOD    4'd10
`define FBOF_SHORT_MIN    4'd2
`define FBOF_IDLE_REP30   6'd30
`define FBOF_IDLE_REP35   6'd35
`define FBOF_IDLE_REP40   6'd40
`define FBOF_GUARD_MIN    3
`define FBOF_GUARD_MAX    10
`define FBOF_OCT_START    8'hd7
`define FBOF_OCT_ESC      8'hd9
`define FBOF_OCT_ESC_D7   8'h00
`define FBOF_OCT_ESC_D9   8'h01
`define FBOF_LEN_HD       4'd11
`define FBOF_LEN_FD       4'd10
`endif

// *** logic/fbof_pkg.sv ***
// types of the octet framer
package fbof_pkg;
  typedef enum logic [1:0] {
    FBOF_REQ_START_LONG, FBOF_REQ_START_SHORT, FBOF_REQ_DATA, FBOF_REQ_END
  } fbof_req_t;
  typedef enum logic [1:0] {FBOF_IND_START, FBOF_IND_DATA, FBOF_IND_IDLE} fbof_ind_t;
  typedef enum logic [2:0] {
    FBOF_ST_SUCCESS, FBOF_ST_STOP_ERR, FBOF_ST_PREMATURE_ADDR, FBOF_ST_MISSING_ADDR,
    FBOF_ST_ESCAPE_ERR, FBOF_ST_IDLE30, FBOF_ST_IDLE35, FBOF_ST_IDLE40
  } fbof_status_t;
  typedef enum logic [1:0] {
    FBOF_TX_IDLE, FBOF_TX_ACTIVE, FBOF_TX_DRAIN, FBOF_TX_GUARD
  } fbof_txst_t;
  typedef enum logic {FBOF_RX_IDLE, FBOF_RX_BITS} fbof_rxst_t;
  typedef enum logic [1:0] {FBOF_ESC_NONE, FBOF_ESC_START, FBOF_ESC_STUFF} fbof_esc_t;
  typedef enum logic [1:0] {FBOF_REG_CTRL, FBOF_REG_DIV, FBOF_REG_STAT, FBOF_REG_NONE} fbof_reg_t;
endpackage

// *** logic/fbof_framer.sv ***
// fieldbus asynchronous octet framer with apb control registers
//
// Contract
// R1: long start waits for idle count eleven
// R2: short start waits for idle mod ten >= 2
// R3: confirm, then transmit enable, then shift out
// R4: data frame after queue frees, bit zero
// R5: half-duplex frames leave back to back
// R6: link layer requests within eleven bit periods
// R7: end waits 3 to 10 bits, drops enable
// R8: address bit or long idle gives start
// R9: start success needs address, stop, idle
// R10: address frame on short idle is premature
// R11: data frame on long idle misses address
// R12: data frame on short idle gives data
// R13: idle counter counts bits, clears on zero
// R14: idle reports at 30, 35, 40, every 10
// R15: msb first nrz, full-duplex ten bit frame
// R16: full-duplex start sends marker then octet
// R17: full-duplex data waits for queue and cts
// R18: escape marker and escape octets are stuffed
// R19: full-duplex end drains, then drops rts
// R20: octet after marker gives start indication
// R21: half-duplex frame carries address/data bit
// R22: escaped octets restored, bad escape flagged
// R23: bit tick from programmable clock divider
`timescale 1ns/1ps
`include "fbof_cfg.svh"
module fbof_framer #(
  parameter logic [15:0] DIV_RESET  = 16'(`FBOF_DIV_RESET),
  parameter int          GUARD_BITS = `FBOF_GUARD_MIN
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 reqValid,
  input  fbof_pkg::fbof_req_t       reqKind,
  input  wire logic [7:0]           reqOctet,
  output logic                      reqConfirm,
  output logic                      indValid,
  output fbof_pkg::fbof_ind_t       indKind,
  output logic      [7:0]           indOctet,
  output fbof_pkg::fbof_status_t    indStatus,
  output logic                      txLine,
  input  wire logic                 rxLine,
  output logic                      transmitEnable,
  output logic                      rts,
  input  wire logic                 cts
);

  function automatic fbof_pkg::fbof_reg_t decode(input logic [11:0] a);
    if (a == `FBOF_ADDR_CTRL) begin
      decode = fbof_pkg::FBOF_REG_CTRL;
    end else if (a == `FBOF_ADDR_DIV) begin
      decode = fbof_pkg::FBOF_REG_DIV;
    end else if (a == `FBOF_ADDR_STAT) begin
      decode = fbof_pkg::FBOF_REG_STAT;
    end else begin
      decode = fbof_pkg::FBOF_REG_NONE;
    end
  endfunction

  // a zero divisor would stall the tick, so it acts as one
  function automatic logic [15:0] reload(input logic [15:0] d);
    reload = (d == 16'h0000) ? 16'h0000 : d - 16'h0001;
  endfunction

  logic                   fd_q, fd_d;
  logic [15:0]            div_q, div_d;
  logic [31:0]            rdata_q, rdata_d;
  logic                   err_q, err_d;
  logic [15:0]            bitCnt_q, bitCnt_d;
  logic                   tick;
  logic [5:0]             idle_q, idle_d;
  logic [3:0]             mod_q, mod_d;
  logic                   idleRep;
  fbof_pkg::fbof_status_t idleSt;
  fbof_pkg::fbof_txst_t   txSt_q, txSt_d;
  logic                   txEn_q, txEn_d;
  logic                   rts_q, rts_d;
  logic [3:0]             guard_q, guard_d;
  logic [10:0]            shReg_q, shReg_d;
  logic [3:0]             shLeft_q, shLeft_d;
  logic [7:0]             qOct_q [2];
  logic [7:0]             qOct_d [2];
  logic                   qAd_q, qAd_d;
  logic [1:0]             qCnt_q, qCnt_d;
  logic                   reqReady, accept, shiftEn, load;
  fbof_pkg::fbof_rxst_t   rxSt_q, rxSt_d;
  logic [15:0]            rxCnt_q, rxCnt_d;
  logic [3:0]             rxIdx_q, rxIdx_d;
  logic [9:0]             rxSh_q, rxSh_d;
  logic                   rxLong_q, rxLong_d;
  logic                   rxDone;
  logic [9:0]             word;
  logic [7:0]             rOct;
  logic                   rAd, rStop;
  fbof_pkg::fbof_esc_t    esc_q, esc_d;
  logic                   indValid_q, indValid_d;
  fbof_pkg::fbof_ind_t    indKind_q, indKind_d;
  logic [7:0]             indOctet_q, indOctet_d;
  fbof_pkg::fbof_status_t indStatus_q, indStatus_d;

  // registers: read data captured in the setup phase, zero wait states
  always_comb begin
    fd_d    = fd_q;
    div_d   = div_q;
    rdata_d = rdata_q;
    err_d   = err_q;
    if (psel && !penable) begin
      err_d   = (decode(paddr) == fbof_pkg::FBOF_REG_NONE);
      rdata_d = 32'h0000_0000;
      case (decode(paddr))
        fbof_pkg::FBOF_REG_CTRL: rdata_d[`FBOF_CTRL_FD_BIT] = fd_q;
        fbof_pkg::FBOF_REG_DIV:  rdata_d[15:0] = div_q;
        fbof_pkg::FBOF_REG_STAT: begin
          rdata_d[5:0]              = idle_q;
          rdata_d[`FBOF_STAT_TXEN]   = txEn_q;
          rdata_d[`FBOF_STAT_RTS]    = rts_q;
          rdata_d[`FBOF_STAT_TXBUSY] = (shLeft_q != 4'h0) || (qCnt_q != 2'h0);
          rdata_d[`FBOF_STAT_RXBUSY] = (rxSt_q == fbof_pkg::FBOF_RX_BITS);
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    if (psel && penable && pwrite) begin
      if (decode(paddr) == fbof_pkg::FBOF_REG_CTRL) begin
        fd_d = pwdata[`FBOF_CTRL_FD_BIT];
      end else if (decode(paddr) == fbof_pkg::FBOF_REG_DIV) begin
        div_d = pwdata[15:0];
      end
    end
  end

  assign prdata  = rdata_q;
  assign pready  = 1'b1;
  assign pslverr = err_q;

  // bit tick
  always_comb begin
    tick     = (bitCnt_q == 16'h0000); // R23
    bitCnt_d = tick ? reload(div_q) : bitCnt_q - 16'h0001; // R23
  end

  // idle counter and line idle reports
  always_comb begin
    idle_d  = idle_q;
    mod_d   = mod_q;
    idleRep = 1'b0;
    idleSt  = fbof_pkg::FBOF_ST_IDLE30;
    if (tick) begin
      if (!txLine || !rxLine) begin
        idle_d = 6'h00; // R13
        mod_d  = 4'h0; // R13
      end else begin
        if (idle_q != `FBOF_IDLE_MAX) begin
          idle_d = idle_q + 6'h01; // R13
        end
        mod_d = (mod_q == `FBOF_SHORT_MOD - 4'h1) ? 4'h0 : mod_q + 4'h1;
        // saturated count keeps ten-bit repeats through the modulo counter
        if (idle_d == `FBOF_IDLE_REP30) begin
          idleRep = !fd_q; // R14
        end else if (idle_d == `FBOF_IDLE_REP35) begin
          idleRep = !fd_q; // R14
          idleSt  = fbof_pkg::FBOF_ST_IDLE35;
        end else if (idle_d >= `FBOF_IDLE_REP40 && mod_d == 4'h0) begin
          idleRep = !fd_q; // R14
          idleSt  = fbof_pkg::FBOF_ST_IDLE40;
        end
      end
    end
  end

  // transmit session, queue and shifter
  always_comb begin
    txSt_d   = txSt_q;
    txEn_d   = txEn_q;
    rts_d    = rts_q;
    guard_d  = guard_q;
    reqReady = 1'b0;
    case (txSt_q)
      fbof_pkg::FBOF_TX_IDLE: begin
        if (reqKind == fbof_pkg::FBOF_REQ_START_LONG) begin
          reqReady = fd_q || (idle_q >= `FBOF_IDLE_LONG); // R1
        end else if (reqKind == fbof_pkg::FBOF_REQ_START_SHORT) begin
          reqReady = fd_q || (mod_q >= `FBOF_SHORT_MIN); // R2
        end else begin
          reqReady = 1'b1;
        end
      end
      fbof_pkg::FBOF_TX_ACTIVE: begin
        if (reqKind == fbof_pkg::FBOF_REQ_DATA) begin
          reqReady = (qCnt_q == 2'h0) && (!fd_q || cts); // R4 R17
        end else if (reqKind == fbof_pkg::FBOF_REQ_END) begin
          reqReady = 1'b1;
        end
      end
      fbof_pkg::FBOF_TX_DRAIN: begin
        if (qCnt_q == 2'h0 && shLeft_q == 4'h0) begin
          guard_d = 4'h0;
          if (fd_q) begin
            rts_d  = 1'b0; // R19
            txSt_d = fbof_pkg::FBOF_TX_IDLE;
          end else begin
            txSt_d = fbof_pkg::FBOF_TX_GUARD;
          end
        end
      end
      default: begin
        if (tick) begin
          guard_d = guard_q + 4'h1;
          if (guard_q == 4'(GUARD_BITS - 1)) begin
            txEn_d = 1'b0; // R7
            txSt_d = fbof_pkg::FBOF_TX_IDLE;
          end
        end
      end
    endcase
    accept = reqValid && reqReady;
    if (accept && reqKind == fbof_pkg::FBOF_REQ_END) begin
      if (txSt_q == fbof_pkg::FBOF_TX_ACTIVE) begin
        txSt_d = fbof_pkg::FBOF_TX_DRAIN; // R7 R19
      end
    end else if (accept && txSt_q == fbof_pkg::FBOF_TX_IDLE
                 && reqKind != fbof_pkg::FBOF_REQ_DATA) begin
      txSt_d = fbof_pkg::FBOF_TX_ACTIVE;
      // enable is seen the cycle after the confirm
      if (fd_q) begin
        rts_d = 1'b1; // R16
      end else begin
        txEn_d = 1'b1; // R3
      end
    end
  end

  assign reqConfirm = reqValid && reqReady;

  always_comb begin
    qOct_d   = qOct_q;
    qAd_d    = qAd_q;
    qCnt_d   = qCnt_q;
    shReg_d  = shReg_q;
    shLeft_d = shLeft_q;
    shiftEn  = fd_q ? (rts_q && cts) : txEn_q; // R3 R16
    load     = tick && shiftEn && (qCnt_q != 2'h0) && (shLeft_q <= 4'h1); // R5
    if (tick && shLeft_q != 4'h0) begin
      shReg_d  = {shReg_q[9:0], 1'b1}; // R15
      shLeft_d = shLeft_q - 4'h1;
    end
    if (load) begin
      shReg_d   = fd_q ? {1'b0, qOct_q[0], 2'b11} : {1'b0, qOct_q[0], qAd_q, 1'b1}; // R15 R21
      shLeft_d  = fd_q ? `FBOF_LEN_FD : `FBOF_LEN_HD; // R15 R21
      qOct_d[0] = qOct_q[1];
      qAd_d     = 1'b0;
      qCnt_d    = qCnt_q - 2'h1;
    end
    // a push only happens with an empty queue, so it never meets a pop
    if (accept && (reqKind != fbof_pkg::FBOF_REQ_END)
        && (txSt_q == fbof_pkg::FBOF_TX_ACTIVE) == (reqKind == fbof_pkg::FBOF_REQ_DATA)) begin
      qOct_d[0] = reqOctet;
      qCnt_d    = 2'h1;
      qAd_d     = (reqKind != fbof_pkg::FBOF_REQ_DATA); // R1 R2 R4
      if (fd_q && reqKind != fbof_pkg::FBOF_REQ_DATA) begin
        qOct_d[0] = `FBOF_OCT_START; // R16
        qOct_d[1] = reqOctet; // R16
        qCnt_d    = 2'h2;
      end else if (fd_q && reqOctet == `FBOF_OCT_START) begin
        qOct_d[0] = `FBOF_OCT_ESC; // R18
        qOct_d[1] = `FBOF_OCT_ESC_D7; // R18
        qCnt_d    = 2'h2;
      end else if (fd_q && reqOctet == `FBOF_OCT_ESC) begin
        qOct_d[0] = `FBOF_OCT_ESC; // R18
        qOct_d[1] = `FBOF_OCT_ESC_D9; // R18
        qCnt_d    = 2'h2;
      end
    end
  end

  assign txLine         = shReg_q[10];
  assign transmitEnable = txEn_q;
  assign rts            = rts_q;

  // receiver: centre sampling from the falling start edge
  always_comb begin
    rxSt_d   = rxSt_q;
    rxCnt_d  = rxCnt_q;
    rxIdx_d  = rxIdx_q;
    rxSh_d   = rxSh_q;
    rxLong_d = rxLong_q;
    rxDone   = 1'b0;
    word     = {rxSh_q[8:0], rxLine};
    if (rxSt_q == fbof_pkg::FBOF_RX_IDLE) begin
      if (!rxLine) begin
        rxCnt_d  = {1'b0, div_q[15:1]};
        rxIdx_d  = 4'h0;
        rxLong_d = (idle_q >= `FBOF_IDLE_LONG); // R8 R9
        rxSt_d   = fbof_pkg::FBOF_RX_BITS;
      end
    end else if (rxCnt_q == 16'h0000) begin
      rxCnt_d = reload(div_q);
      if (rxIdx_q == 4'h0 && rxLine) begin
        rxSt_d = fbof_pkg::FBOF_RX_IDLE; // glitch, not a start bit
      end else begin
        rxIdx_d = rxIdx_q + 4'h1;
        if (rxIdx_q != 4'h0) begin
          rxSh_d = word;
        end
        if (rxIdx_q == (fd_q ? `FBOF_LEN_FD : `FBOF_LEN_HD) - 4'h1) begin
          rxDone = 1'b1;
          rxSt_d = fbof_pkg::FBOF_RX_IDLE;
        end
      end
    end else begin
      rxCnt_d = rxCnt_q - 16'h0001;
    end
    rOct  = fd_q ? word[8:1] : word[9:2]; // R15
    rAd   = word[1]; // R21
    rStop = word[0];
  end

  // indications; a finished frame wins over an idle report
  always_comb begin
    esc_d       = esc_q;
    indValid_d  = 1'b0;
    indKind_d   = indKind_q;
    indOctet_d  = indOctet_q;
    indStatus_d = indStatus_q;
    if (rxDone) begin
      indValid_d  = 1'b1;
      indOctet_d  = rOct;
      indKind_d   = fbof_pkg::FBOF_IND_DATA;
      indStatus_d = rStop ? fbof_pkg::FBOF_ST_SUCCESS : fbof_pkg::FBOF_ST_STOP_ERR; // R9 R12 R20
      if (!fd_q) begin
        if (rAd || rxLong_q) begin
          indKind_d = fbof_pkg::FBOF_IND_START; // R8
          if (rStop && !rxLong_q) begin
            indStatus_d = fbof_pkg::FBOF_ST_PREMATURE_ADDR; // R10
          end else if (rStop && !rAd) begin
            indStatus_d = fbof_pkg::FBOF_ST_MISSING_ADDR; // R11
          end
        end
      end else begin
        case (esc_q)
          fbof_pkg::FBOF_ESC_NONE: begin
            if (rOct == `FBOF_OCT_START) begin
              indValid_d = 1'b0; // R20
              esc_d      = fbof_pkg::FBOF_ESC_START;
            end else if (rOct == `FBOF_OCT_ESC && rStop) begin
              indValid_d = 1'b0; // R22
              esc_d      = fbof_pkg::FBOF_ESC_STUFF;
            end
          end
          fbof_pkg::FBOF_ESC_START: begin
            indKind_d = fbof_pkg::FBOF_IND_START; // R20
            esc_d     = fbof_pkg::FBOF_ESC_NONE;
          end
          default: begin
            esc_d = fbof_pkg::FBOF_ESC_NONE;
            if (rStop && rOct == `FBOF_OCT_ESC_D7) begin
              indOctet_d = `FBOF_OCT_START; // R22
            end else if (rStop && rOct == `FBOF_OCT_ESC_D9) begin
              indOctet_d = `FBOF_OCT_ESC; // R22
            end else if (rStop) begin
              indStatus_d = fbof_pkg::FBOF_ST_ESCAPE_ERR; // R22
            end
          end
        endcase
      end
    end else if (idleRep) begin
      indValid_d  = 1'b1; // R14
      indKind_d   = fbof_pkg::FBOF_IND_IDLE;
      indOctet_d  = 8'h00;
      indStatus_d = idleSt;
    end
  end

  assign indValid  = indValid_q;
  assign indKind   = indKind_q;
  assign indOctet  = indOctet_q;
  assign indStatus = indStatus_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      fd_q        <= 1'b0;
      div_q       <= DIV_RESET;
      rdata_q     <= 32'h0000_0000;
      err_q       <= 1'b0;
      bitCnt_q    <= 16'h0000;
      idle_q      <= 6'h00;
      mod_q       <= 4'h0;
      txSt_q      <= fbof_pkg::FBOF_TX_IDLE;
      txEn_q      <= 1'b0;
      rts_q       <= 1'b0;
      guard_q     <= 4'h0;
      shReg_q     <= 11'h7ff;
      shLeft_q    <= 4'h0;
      qOct_q[0]   <= 8'h00;
      qOct_q[1]   <= 8'h00;
      qAd_q       <= 1'b0;
      qCnt_q      <= 2'h0;
      rxSt_q      <= fbof_pkg::FBOF_RX_IDLE;
      rxCnt_q     <= 16'h0000;
      rxIdx_q     <= 4'h0;
      rxSh_q      <= 10'h000;
      rxLong_q    <= 1'b0;
      esc_q       <= fbof_pkg::FBOF_ESC_NONE;
      indValid_q  <= 1'b0;
      indKind_q   <= fbof_pkg::FBOF_IND_DATA;
      indOctet_q  <= 8'h00;
      indStatus_q <= fbof_pkg::FBOF_ST_SUCCESS;
    end else begin
      fd_q        <= fd_d;
      div_q       <= div_d;
      rdata_q     <= rdata_d;
      err_q       <= err_d;
      bitCnt_q    <= bitCnt_d;
      idle_q      <= idle_d;
      mod_q       <= mod_d;
      txSt_q      <= txSt_d;
      txEn_q      <= txEn_d;
      rts_q       <= rts_d;
      guard_q     <= guard_d;
      shReg_q     <= shReg_d;
      shLeft_q    <= shLeft_d;
      qOct_q      <= qOct_d;
      qAd_q       <= qAd_d;
      qCnt_q      <= qCnt_d;
      rxSt_q      <= rxSt_d;
      rxCnt_q     <= rxCnt_d;
      rxIdx_q     <= rxIdx_d;
      rxSh_q      <= rxSh_d;
      rxLong_q    <= rxLong_d;
      esc_q       <= esc_d;
      indValid_q  <= indValid_d;
      indKind_q   <= indKind_d;
      indOctet_q  <= indOctet_d;
      indStatus_q <= indStatus_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_long_wait: assert property ( // R1
    (reqConfirm && !fd_q && txSt_q == fbof_pkg::FBOF_TX_IDLE
     && reqKind == fbof_pkg::FBOF_REQ_START_LONG) |-> idle_q >= 6'd11)
    else $error("long start confirmed before eleven idle bits");
  chk_short_wait: assert property ( // R2
    (reqConfirm && !fd_q && txSt_q == fbof_pkg::FBOF_TX_IDLE
     && reqKind == fbof_pkg::FBOF_REQ_START_SHORT) |-> mod_q >= 4'd2)
    else $error("short start confirmed too early");
  chk_confirm_first: assert property ( // R3
    (reqConfirm && !fd_q && txSt_q == fbof_pkg::FBOF_TX_IDLE
     && reqKind != fbof_pkg::FBOF_REQ_DATA && reqKind != fbof_pkg::FBOF_REQ_END)
    |-> !txEn_q && shLeft_q == 4'h0 ##1 txEn_q && shLeft_q == 4'h0)
    else $error("enable or shifting out of order after start");
  chk_back_to_back: assert property ( // R5
    (tick && !fd_q && txEn_q && shLeft_q == 4'h1 && qCnt_q != 2'h0)
    |=> shLeft_q == 4'd11 && !txLine)
    else $error("gap between half-duplex frames");
  chk_guard_time: assert property ( // R7
    $fell(txEn_q) |-> $past(txSt_q) == fbof_pkg::FBOF_TX_GUARD
                      && $past(guard_q) == 4'(GUARD_BITS - 1) && txLine)
    else $error("transmit enable dropped without guard time");
  chk_idle_clear: assert property ( // R13
    (tick && (!txLine || !rxLine)) |=> idle_q == 6'h00)
    else $error("idle counter not cleared by zero bit");
  chk_idle_report: assert property ( // R14
    (tick && !fd_q && idle_q == 6'd29 && txLine && rxLine && !rxDone)
    |=> indValid_q && indStatus_q == fbof_pkg::FBOF_ST_IDLE30)
    else $error("missing thirty bit idle report");
  chk_fd_start: assert property ( // R16
    (reqConfirm && fd_q && txSt_q == fbof_pkg::FBOF_TX_IDLE
     && reqKind != fbof_pkg::FBOF_REQ_DATA && reqKind != fbof_pkg::FBOF_REQ_END)
    |=> qCnt_q == 2'h2 && qOct_q[0] == 8'hd7 && qOct_q[1] == $past(reqOctet) && rts_q)
    else $error("full-duplex start not queued behind marker");
  chk_cts_gate: assert property ( // R16 R17
    (load && fd_q) |-> rts_q && cts)
    else $error("full-duplex frame started without rts and cts");
  chk_stuff_pair: assert property ( // R18
    (reqConfirm && fd_q && txSt_q == fbof_pkg::FBOF_TX_ACTIVE
     && reqKind == fbof_pkg::FBOF_REQ_DATA && reqOctet == 8'hd7)
    |=> qCnt_q == 2'h2 && qOct_q[0] == 8'hd9 && qOct_q[1] == 8'h00)
    else $error("escape marker octet not stuffed");
endmodule

// *** tb/fbof_line_model.sv ***
// line driver model: serial frame source and delayed clear-to-send
`timescale 1ns/1ps
module fbof_line_model #(
  parameter int BIT_CYC = 8
) (
  input  wire logic clk,
  input  wire logic rts,
  output logic      cts,
  output logic      rxLine
);
  logic [3:0] ctsDly = 4'h0;
  initial rxLine = 1'b1;
  // cts trails rts so the framer must really wait for it
  always @(posedge clk) ctsDly <= {ctsDly[2:0], rts};
  assign cts = ctsDly[3];
  // index 0 leaves first; line rests high (idle level) after the frame
  task automatic sendBits(input logic [10:0] b, input int nb);
    for (int i = 0; i < nb; i++) begin
      rxLine <= b[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    // one idle cycle, so a following frame never drives the line twice at one edge
    rxLine <= 1'b1;
    @(posedge clk);
  endtask
endmodule

// *** tb/tb_top.sv ***
// self-checking bench of the octet framer
`timescale 1ns/1ps
module tb_top;
  localparam int DV = 8;
  localparam logic [1:0] KS = fbof_pkg::FBOF_IND_START;
  localparam logic [1:0] KD = fbof_pkg::FBOF_IND_DATA;
  localparam logic [2:0] SU = fbof_pkg::FBOF_ST_SUCCESS;
  localparam logic [2:0] SE = fbof_pkg::FBOF_ST_STOP_ERR;
  logic                   clk, reset, psel, penable, pwrite, pready, pslverr, er;
  logic                   reqValid, reqConfirm, indValid, txLine, rxLine, transmitEnable, rts, cts;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, rd;
  fbof_pkg::fbof_req_t    reqKind;
  fbof_pkg::fbof_ind_t    indKind;
  fbof_pkg::fbof_status_t indStatus;
  logic [7:0]             reqOctet, indOctet, lastOct;
  logic [1:0]             lastKind;
  logic [2:0]             lastSt;
  logic [39:0]            v;
  int                     errors = 0, checks = 0, indCnt = 0, cyc = 0, lastT = 0, n, t0;
  // stop, ad, long idle, octet, kind, status
  logic [15:0] hdRow [6] = '{{3'b111, 8'ha5, KS, SU}, {3'b100, 8'h3c, KD, SU},
    {3'b000, 8'h3c, KD, SE}, {3'b110, 8'h5a, KS, fbof_pkg::FBOF_ST_PREMATURE_ADDR},
    {3'b101, 8'h66, KS, fbof_pkg::FBOF_ST_MISSING_ADDR}, {3'b011, 8'h81, KS, SE}};
  // octet pair sent, octet, kind, status
  logic [28:0] fdRow [3] = '{{16'hd744, 8'h44, KS, SU}, {16'hd900, 8'hd7, KD, SU},
    {16'hd955, 8'h55, KD, fbof_pkg::FBOF_ST_ESCAPE_ERR}};
  logic [2:0] idSt [4] = '{fbof_pkg::FBOF_ST_IDLE30, fbof_pkg::FBOF_ST_IDLE35,
    fbof_pkg::FBOF_ST_IDLE40, fbof_pkg::FBOF_ST_IDLE40};
  fbof_framer #(.DIV_RESET(16'(DV)), .GUARD_BITS(3)) DUT (.clk, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reqValid, .reqKind, .reqOctet,
    .reqConfirm, .indValid, .indKind, .indOctet, .indStatus, .txLine, .rxLine,
    .transmitEnable, .rts, .cts);
  fbof_line_model #(.BIT_CYC(DV)) LM (.clk, .rts, .cts, .rxLine);
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (indValid === 1'b1) begin
      indCnt <= indCnt + 1;
      lastKind <= indKind;
      lastOct <= indOctet;
      lastSt <= indStatus;
      lastT <= cyc;
    end
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic expire;
    errors++;
    $display("Error at %0t: wait bound used up %h %h", $time, txLine, rts);
    finish_test();
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return txLine;
      1: return transmitEnable;
      2: return rts;
      default: return reqConfirm;
    endcase
  endfunction
  task automatic waitSig(input int k, input logic val, input int lim);
    for (int i = 0; i <= lim; i++) begin
      @(posedge clk);
      if (pick(k) === val) return;
    end
    expire();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
      if (i == 15) expire();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // one idle edge after each request keeps reqValid from being driven twice at once
  task automatic req(input fbof_pkg::fbof_req_t k, input logic [7:0] o);
    reqValid <= 1'b1;
    reqKind <= k;
    reqOctet <= o;
    waitSig(3, 1'b1, 300 * DV);
    reqValid <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [7:0] rev(input logic [7:0] d);
    for (int i = 0; i < 8; i++) rev[i] = d[7 - i];
  endfunction
  // line order from index 0: start, msb first, address/data bit, stop
  function automatic logic [10:0] hdF(input logic s, input logic ad, input logic [7:0] d);
    return {s, ad, rev(d), 1'b0};
  endfunction
  function automatic logic [9:0] fdF(input logic [7:0] d);
    return {1'b1, rev(d), 1'b0};
  endfunction
  // samples each bit at its centre; k names the enable that must already stand
  task automatic grab(input int nb, input int k);
    waitSig(0, 1'b0, 300 * DV);
    chk(32'(pick(k)), 1);
    repeat (DV / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      v[i] = txLine;
      if (i < nb - 1) repeat (DV) @(posedge clk);
    end
  endtask
  task automatic rowChk(input int c, input logic [12:0] e);
    repeat (2) @(posedge clk);
    chk(32'(indCnt - c), 1);
    chk(lastOct, e[12:5]);
    chk(lastKind, e[4:3]);
    chk(lastSt, e[2:0]);
  endtask
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    {psel, penable, pwrite, reqValid} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    reqKind = fbof_pkg::FBOF_REQ_DATA;
    reqOctet = 8'h00;
    v = '1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk(txLine, 1);
    chk({transmitEnable, rts}, 0);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) continue;
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(rd, (i == 1) ? DV : 0);
      chk(er, i == 3);
    end
    $display("reset and registers done");
    for (int i = 0; i < 6; i++) begin
      if (hdRow[i][13]) repeat (14 * DV) @(posedge clk);
      t0 = indCnt;
      LM.sendBits(hdF(hdRow[i][15], hdRow[i][14], hdRow[i][12:5]), 11);
      rowChk(t0, hdRow[i][12:0]);
    end
    $display("half-duplex receive done");
    for (int j = 0; j < 4; j++) begin
      t0 = lastT;
      n = indCnt;
      for (int i = 0; indCnt == n; i++) begin
        if (i > 45 * DV) expire();
        @(posedge clk);
      end
      chk(lastSt, idSt[j]);
    end
    chk(32'(lastT - t0), 10 * DV);
    $display("idle reports done");
    fork
      grab(22, 1);
      begin
        req(fbof_pkg::FBOF_REQ_START_LONG, 8'ha5);
        req(fbof_pkg::FBOF_REQ_DATA, 8'h3c);
        req(fbof_pkg::FBOF_REQ_END, 8'h00);
      end
    join
    chk(v[21:0], {hdF(1'b1, 1'b0, 8'h3c), hdF(1'b1, 1'b1, 8'ha5)});
    for (n = 0; transmitEnable === 1'b1 && n < 12 * DV; n++) @(posedge clk);
    chk(n >= DV / 2 + 3 * DV && n <= DV / 2 + 10 * DV + 2, 1);
    fork
      grab(11, 1);
      begin
        req(fbof_pkg::FBOF_REQ_START_SHORT, 8'h5a);
        req(fbof_pkg::FBOF_REQ_END, 8'h00);
      end
    join
    chk(v[10:0], hdF(1'b1, 1'b1, 8'h5a));
    waitSig(1, 1'b0, 12 * DV);
    $display("half-duplex transmit done");
    apb(1'b1, 12'h000, 32'h1);
    fork
      grab(40, 2);
      begin
        req(fbof_pkg::FBOF_REQ_START_SHORT, 8'h12);
        req(fbof_pkg::FBOF_REQ_DATA, 8'hd7);
        req(fbof_pkg::FBOF_REQ_END, 8'h00);
      end
    join
    chk(v[39:20], {fdF(8'h00), fdF(8'hd9)});
    chk(v[19:0], {fdF(8'h12), fdF(8'hd7)});
    waitSig(2, 1'b0, 2 * DV);
    for (int i = 0; i < 3; i++) begin
      t0 = indCnt;
      LM.sendBits({1'b1, fdF(fdRow[i][28:21])}, 10);
      LM.sendBits({1'b1, fdF(fdRow[i][20:13])}, 10);
      rowChk(t0, fdRow[i][12:0]);
    end
    $display("full-duplex done");
    finish_test();
  end
endmodule
